// ===== common/psr_pkg.sv
package psr_pkg;
   localparam int NUM_PORTS = 3;
   localparam int IDX_W = 8;
   // Printed offsets are register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_PORT1_STATUS1 = 8'h1f;
   localparam logic [IDX_W-1:0] IDX_PORT2_STATUS1 = 8'h2f;
   localparam logic [IDX_W-1:0] IDX_PORT3_STATUS1 = 8'h3f;
   localparam logic [IDX_W-1:0] IDX_GLOBAL_RESET = 8'h43;
   localparam logic [IDX_W-1:0] IDX_INT_STATUS = 8'h50;
   localparam logic [IDX_W-1:0] IDX_INT_MASK = 8'h51;
   localparam logic [IDX_W-1:0] IDX_RATE_BASE = 8'h60;
   // Status-1 field positions
   localparam int BIT_XSEL = 7;
   localparam int BIT_POL = 5;
   localparam int BIT_TXFC = 4;
   localparam int BIT_RXFC = 3;
   localparam int BIT_SPEED = 2;
   localparam int BIT_DUPLEX = 1;
   localparam int BIT_FEF = 0;
   // Reset register field positions
   localparam int BIT_SWRST = 4;
   localparam int BIT_PCSRST = 0;
   localparam logic XSEL_RESET = 1'h1;
   localparam logic [7:0] GLOBAL_RESET_RESET = 8'h00;
   localparam logic [2:0] INT_MASK_RESET = 3'h0;
   localparam logic [6:0] RATE_CODE_RESET = 7'h00;
   // Rate-limit code points
   localparam logic [6:0] RATE_FULL_100 = 7'h64;
   localparam logic [6:0] RATE_MAX_100 = 7'h63;
   localparam logic [6:0] RATE_FULL_10 = 7'h0a;
   localparam logic [6:0] RATE_MAX_10 = 7'h09;
   localparam logic [6:0] RATE_KBPS_FIRST = 7'h65;
   localparam logic [6:0] RATE_KBPS_LAST = 7'h73;
   localparam int KBPS_W = 17;
   localparam logic [KBPS_W-1:0] KBPS_LINE_100 = 17'h186a0;
   localparam logic [KBPS_W-1:0] KBPS_LINE_10 = 17'h02710;
   localparam logic [KBPS_W-1:0] KBPS_PER_MBPS = 17'h003e8;
   localparam logic [KBPS_W-1:0] KBPS_STEP = 17'h00040;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [1:0] {
      PSR_SPEED10_LIMIT = 2'b00,
      PSR_MBPS_LIMIT = 2'b01,
      PSR_KBPS_LIMIT = 2'b10,
      PSR_NO_LIMIT = 2'b11
   } psr_limit_type;
endpackage : psr_pkg

// ===== rtl/psr_port_status_regs.sv
// Behaviour
// - Status-1 bit 7 is read/write crossover algorithm select, resetting to 1.
// - Crossover select drives only ports 1 and 2; port 3 value is ignored.
// - Bit 5 reads 1 when receive polarity is reversed; resets to 0.
// - Polarity flag counts only at 10BT and never on port 3.
// - Bit 4 reads 1 while transmit flow control is active.
// - Bit 3 reads 1 while receive flow control is active.
// - Bit 2 reports resolved speed: 1 for 100 Mbps, 0 for 10.
// - Bit 1 reports resolved duplex: 1 full, 0 half.
// - Bit 0 reports far-end fault, on port 1 only.
// - Reset bit 4 returns all registers to reset values; writing 0 clears it. The reset register itself keeps its value.
// - Reset bit 0 resets the coding sublayer; writing 0 clears it.
// - Each rate limit is a 7-bit field in bits 6:0, per queue.
// - At 100BT codes 1 to 0x63 limit to 1 to 99 Mbps.
// - At 100BT code 0 or 0x64 means no limit, 100 Mbps.
// - At 10BT codes 1 to 0x09 limit to 1 to 9 Mbps.
// - At 10BT code 0 or 0x0A means no limit, 10 Mbps.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module psr_port_status_regs #(
   parameter int NUM_QUEUES = 4
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [psr_pkg::NUM_PORTS-1:0] polarityReversed,
   input wire logic [psr_pkg::NUM_PORTS-1:0] txFlowActive,
   input wire logic [psr_pkg::NUM_PORTS-1:0] rxFlowActive,
   input wire logic [psr_pkg::NUM_PORTS-1:0] speed100,
   input wire logic [psr_pkg::NUM_PORTS-1:0] fullDuplex,
   input wire logic [psr_pkg::NUM_PORTS-1:0] farEndFault,
   output logic [1:0] crossover_algorithm_select,
   output logic coding_sublayer_reset,
   output logic softwareResetActive,
   output logic [psr_pkg::NUM_PORTS*2*NUM_QUEUES*psr_pkg::KBPS_W-1:0] rateLimitKbps,
   output logic irq
);
   import psr_pkg::*;
   localparam int NUM_RATE = NUM_PORTS * 2 * NUM_QUEUES;

   logic [7:0] globalReset;
   logic clearAll;
   logic [NUM_PORTS-1:0] crossoverSel;
   logic [5:0] statusLive [NUM_PORTS];
   logic [7:0] statusView [NUM_PORTS];
   logic [NUM_PORTS-1:0] intStatus;
   logic [NUM_PORTS-1:0] intMask;
   logic [NUM_PORTS-1:0] statusEvent;
   logic [6:0] rateCode [NUM_RATE];
   logic awHeld;
   logic wHeld;
   logic [IDX_W-1:0] wrIndex;
   logic [31:0] wrData;
   logic wrLane0;
   logic doWrite;
   logic wrHit;
   logic [IDX_W-1:0] rdIndex;
   logic [7:0] rdMux;
   logic rdHit;

   // Whole register file, reset register excluded, held while software reset stands
   assign clearAll = sys_rst | globalReset[BIT_SWRST];
   assign softwareResetActive = globalReset[BIT_SWRST];
   assign coding_sublayer_reset = globalReset[BIT_PCSRST];
   // Port 3 is an MII port, so its select bit steers nothing
   assign crossover_algorithm_select = crossoverSel[1:0];

   // Write channel: address and data taken independently
   assign s_axi_awready = !awHeld;
   assign s_axi_wready = !wHeld;
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         awHeld <= 1'b0;
         wrIndex <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld <= 1'b1;
         wrIndex <= s_axi_awaddr[IDX_W+1:2];
      end else if (doWrite) begin
         awHeld <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wHeld <= 1'b0;
         wrData <= '0;
         wrLane0 <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld <= 1'b1;
         wrData <= s_axi_wdata;
         wrLane0 <= s_axi_wstrb[0];
      end else if (doWrite) begin
         wHeld <= 1'b0;
      end
   end

   always_comb begin
      wrHit = 1'b0;
      if (wrIndex == IDX_PORT1_STATUS1 || wrIndex == IDX_PORT2_STATUS1
          || wrIndex == IDX_PORT3_STATUS1 || wrIndex == IDX_GLOBAL_RESET
          || wrIndex == IDX_INT_STATUS || wrIndex == IDX_INT_MASK) begin
         wrHit = 1'b1;
      end
      if (wrIndex >= IDX_RATE_BASE && wrIndex < IDX_RATE_BASE + IDX_W'(NUM_RATE)) begin
         wrHit = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrHit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Reset register survives its own software reset, so writing 0 is the release
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         globalReset <= GLOBAL_RESET_RESET;
      end else if (doWrite && wrLane0 && wrIndex == IDX_GLOBAL_RESET) begin
         globalReset <= 8'h00;
         globalReset[BIT_SWRST] <= wrData[BIT_SWRST];
         globalReset[BIT_PCSRST] <= wrData[BIT_PCSRST];
      end
   end

   always_ff @(posedge core_clk) begin
      if (clearAll) begin
         crossoverSel <= {NUM_PORTS{XSEL_RESET}};
      end else if (doWrite && wrLane0) begin
         if (wrIndex == IDX_PORT1_STATUS1) crossoverSel[0] <= wrData[BIT_XSEL];
         if (wrIndex == IDX_PORT2_STATUS1) crossoverSel[1] <= wrData[BIT_XSEL];
         if (wrIndex == IDX_PORT3_STATUS1) crossoverSel[2] <= wrData[BIT_XSEL];
      end
   end

   // Live status sampled once per cycle; events are any change of a port's live status bits, not the crossover select bit
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      always_ff @(posedge core_clk) begin
         if (clearAll) begin
            statusLive[p] <= 6'h00;
         end else begin
            // Polarity only meaningful at 10BT on a PHY port
            statusLive[p][BIT_POL] <= (p != 2) && polarityReversed[p] && !speed100[p];
            statusLive[p][BIT_TXFC] <= txFlowActive[p];
            statusLive[p][BIT_RXFC] <= rxFlowActive[p];
            statusLive[p][BIT_SPEED] <= speed100[p];
            statusLive[p][BIT_DUPLEX] <= fullDuplex[p];
            statusLive[p][BIT_FEF] <= (p == 0) && farEndFault[p];
         end
      end
      assign statusView[p] = {crossoverSel[p], 1'b0, statusLive[p]};
      assign statusEvent[p] = !clearAll && (statusLive[p] != {
         (p != 2) && polarityReversed[p] && !speed100[p], txFlowActive[p],
         rxFlowActive[p], speed100[p], fullDuplex[p], (p == 0) && farEndFault[p]});
   end

   // Set wins over a simultaneous write-one clear
   always_ff @(posedge core_clk) begin
      if (clearAll) begin
         intStatus <= '0;
      end else if (doWrite && wrLane0 && wrIndex == IDX_INT_STATUS) begin
         intStatus <= (intStatus & ~wrData[NUM_PORTS-1:0]) | statusEvent;
      end else begin
         intStatus <= intStatus | statusEvent;
      end
   end

   always_ff @(posedge core_clk) begin
      if (clearAll) begin
         intMask <= INT_MASK_RESET;
      end else if (doWrite && wrLane0 && wrIndex == IDX_INT_MASK) begin
         intMask <= wrData[NUM_PORTS-1:0];
      end
   end

   assign irq = |(intStatus & intMask);

   // Rate-limit fields: port-major, ingress then egress, then queue
   for (genvar e = 0; e < NUM_RATE; e++) begin : g_rate
      localparam int PORT = e / (2 * NUM_QUEUES);
      logic [KBPS_W-1:0] nextKbps;
      always_ff @(posedge core_clk) begin
         if (clearAll) begin
            rateCode[e] <= RATE_CODE_RESET;
         end else if (doWrite && wrLane0 && wrIndex == IDX_RATE_BASE + IDX_W'(e)) begin
            rateCode[e] <= wrData[6:0];
         end
      end
      always_comb begin
         if (rateCode[e] >= RATE_KBPS_FIRST && rateCode[e] <= RATE_KBPS_LAST) begin
            nextKbps = KBPS_W'(rateCode[e] - RATE_FULL_100) * KBPS_STEP;
         end else if (statusLive[PORT][BIT_SPEED]) begin
            if (rateCode[e] != 7'h00 && rateCode[e] <= RATE_MAX_100) begin
               nextKbps = KBPS_W'(rateCode[e]) * KBPS_PER_MBPS;
            end else begin
               nextKbps = KBPS_LINE_100;
            end
         end else begin
            if (rateCode[e] != 7'h00 && rateCode[e] <= RATE_MAX_10) begin
               nextKbps = KBPS_W'(rateCode[e]) * KBPS_PER_MBPS;
            end else begin
               // Codes between 0x0b and 0x64 have no 10BT meaning; left unlimited
               nextKbps = KBPS_LINE_10;
            end
         end
      end
      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            rateLimitKbps[e*KBPS_W +: KBPS_W] <= KBPS_LINE_10;
         end else begin
            rateLimitKbps[e*KBPS_W +: KBPS_W] <= nextKbps;
         end
      end
      // Mbps, kbps and 10BT no-limit decode checked on every entry, one cycle after code and speed
      a_rate_mbps_100: assert property (@(posedge core_clk) disable iff (sys_rst)
         statusLive[PORT][BIT_SPEED] && rateCode[e] != 7'h00 && rateCode[e] <= RATE_MAX_100
         |=> rateLimitKbps[e*KBPS_W +: KBPS_W] == KBPS_W'($past(rateCode[e])) * KBPS_PER_MBPS)
         else $error("Mbps code wrong at 100BT");
      a_rate_mbps_10: assert property (@(posedge core_clk) disable iff (sys_rst)
         !statusLive[PORT][BIT_SPEED] && rateCode[e] != 7'h00 && rateCode[e] <= RATE_MAX_10
         |=> rateLimitKbps[e*KBPS_W +: KBPS_W] == KBPS_W'($past(rateCode[e])) * KBPS_PER_MBPS)
         else $error("Mbps code wrong at 10BT");
      a_rate_unlimited_10: assert property (@(posedge core_clk) disable iff (sys_rst)
         !statusLive[PORT][BIT_SPEED] && (rateCode[e] == 7'h00 || rateCode[e] == RATE_FULL_10)
         |=> rateLimitKbps[e*KBPS_W +: KBPS_W] == KBPS_LINE_10)
         else $error("no-limit code wrong at 10BT");
      a_rate_kbps_step: assert property (@(posedge core_clk) disable iff (sys_rst)
         rateCode[e] >= RATE_KBPS_FIRST && rateCode[e] <= RATE_KBPS_LAST
         |=> rateLimitKbps[e*KBPS_W +: KBPS_W]
             == KBPS_STEP * KBPS_W'($past(rateCode[e]) - RATE_FULL_100))
         else $error("kbps code wrong");
   end

   // Read channel: one read at a time, data one cycle after the address
   assign s_axi_arready = !s_axi_rvalid;
   assign rdIndex = s_axi_araddr[IDX_W+1:2];

   always_comb begin
      rdMux = 8'h00;
      rdHit = 1'b1;
      case (rdIndex)
         IDX_PORT1_STATUS1: rdMux = statusView[0];
         IDX_PORT2_STATUS1: rdMux = statusView[1];
         IDX_PORT3_STATUS1: rdMux = statusView[2];
         IDX_GLOBAL_RESET: rdMux = globalReset;
         IDX_INT_STATUS: rdMux = {5'h00, intStatus};
         IDX_INT_MASK: rdMux = {5'h00, intMask};
         default: rdHit = 1'b0;
      endcase
      for (int i = 0; i < NUM_RATE; i++) begin
         if (rdIndex == IDX_RATE_BASE + IDX_W'(i)) begin
            rdMux = {1'b0, rateCode[i]};
            rdHit = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rdMux};
         s_axi_rresp <= rdHit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Per-bit checks watch one port each, polarity ports 1 and 3, far-end fault ports 2 and 3; polarity and far-end fault logic differ by port
   a_xsel_after_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
      $past(sys_rst) |-> crossover_algorithm_select == 2'b11)
      else $error("crossover select not 1 after reset");
   a_xsel_write_lands: assert property (@(posedge core_clk) disable iff (sys_rst)
      doWrite && wrLane0 && wrIndex == IDX_PORT1_STATUS1 && !clearAll
      |=> crossover_algorithm_select[0] == $past(wrData[BIT_XSEL]))
      else $error("crossover select write lost");
   a_port3_xsel_kept: assert property (@(posedge core_clk) disable iff (sys_rst)
      doWrite && wrIndex == IDX_PORT3_STATUS1 && !clearAll
      |=> $stable(crossover_algorithm_select))
      else $error("port 3 write reached crossover select");
   a_pol_report: assert property (@(posedge core_clk) disable iff (sys_rst)
      !$past(clearAll) && !$past(speed100[0])
      |-> statusView[0][BIT_POL] == $past(polarityReversed[0]))
      else $error("polarity bit does not follow input");
   a_pol_speed_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      $past(speed100[0]) && !$past(clearAll) |-> !statusView[0][BIT_POL])
      else $error("polarity shown at 100BT");
   a_port3_pol_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      !statusView[2][BIT_POL])
      else $error("polarity shown on port 3");
   a_tx_fc_track: assert property (@(posedge core_clk) disable iff (sys_rst)
      !$past(clearAll) |-> statusView[1][BIT_TXFC] == $past(txFlowActive[1]))
      else $error("tx flow bit does not follow input");
   a_rx_fc_track: assert property (@(posedge core_clk) disable iff (sys_rst)
      !$past(clearAll) |-> statusView[0][BIT_RXFC] == $past(rxFlowActive[0]))
      else $error("rx flow bit does not follow input");
   a_speed_track: assert property (@(posedge core_clk) disable iff (sys_rst)
      !$past(clearAll) |-> statusView[0][BIT_SPEED] == $past(speed100[0]))
      else $error("speed bit does not follow input");
   a_duplex_track: assert property (@(posedge core_clk) disable iff (sys_rst)
      !$past(clearAll) |-> statusView[2][BIT_DUPLEX] == $past(fullDuplex[2]))
      else $error("duplex bit does not follow input");
   a_fef_port1_only: assert property (@(posedge core_clk) disable iff (sys_rst)
      !statusView[1][BIT_FEF] && !statusView[2][BIT_FEF])
      else $error("far-end fault shown off port 1");
   a_soft_reset_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
      softwareResetActive |=> intStatus == '0 && crossoverSel == 3'b111)
      else $error("software reset left state");
   a_swrst_write_lands: assert property (@(posedge core_clk) disable iff (sys_rst)
      doWrite && wrLane0 && wrIndex == IDX_GLOBAL_RESET
      |=> softwareResetActive == $past(wrData[BIT_SWRST]))
      else $error("software reset not written");
   a_pcs_write_lands: assert property (@(posedge core_clk) disable iff (sys_rst)
      doWrite && wrLane0 && wrIndex == IDX_GLOBAL_RESET
      |=> coding_sublayer_reset == $past(wrData[BIT_PCSRST]))
      else $error("coding sublayer reset not written");
   a_rate_unlimited_100: assert property (@(posedge core_clk) disable iff (sys_rst)
      statusLive[0][BIT_SPEED] && rateCode[0] == RATE_FULL_100
      |=> rateLimitKbps[KBPS_W-1:0] == KBPS_LINE_100)
      else $error("0x64 not unlimited at 100BT");
   a_rate_kbps_first: assert property (@(posedge core_clk) disable iff (sys_rst)
      rateCode[0] == RATE_KBPS_FIRST |=> rateLimitKbps[KBPS_W-1:0] == KBPS_STEP)
      else $error("0x65 not 64 kbps");
   a_int_set_wins: assert property (@(posedge core_clk) disable iff (sys_rst)
      statusEvent[0] |=> intStatus[0])
      else $error("status event not latched");
   a_int_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      doWrite && wrLane0 && wrIndex == IDX_INT_STATUS && wrData[0] && !statusEvent[0]
      |=> !intStatus[0])
      else $error("write-one did not clear status");
   a_bresp_after_both: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(s_axi_bvalid) |-> $past(awHeld) && $past(wHeld))
      else $error("write response before address and data");
   a_rvalid_after_ar: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read data after address");
   a_unmapped_decerr: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_axi_arvalid && s_axi_arready && !rdHit
      |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h00000000)
      else $error("unmapped read not refused");

   c_soft_reset: cover property (@(posedge core_clk) disable iff (sys_rst)
      $rose(softwareResetActive));
   c_irq_raised: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(irq));
   c_kbps_limit: cover property (@(posedge core_clk) disable iff (sys_rst)
      rateCode[0] == RATE_KBPS_LAST);
   c_read_status: cover property (@(posedge core_clk) disable iff (sys_rst)
      s_axi_arvalid && s_axi_arready && rdIndex == IDX_PORT1_STATUS1);
   c_decerr_read: cover property (@(posedge core_clk) disable iff (sys_rst)
      s_axi_rvalid && s_axi_rresp == RESP_DECERR);
endmodule : psr_port_status_regs

// ===== bench/testbench.sv
`timescale 1ns/1ns
module testbench;
   import psr_pkg::*;
   localparam int NQ = 4;
   typedef struct {logic [2:0] pol, tx, rx, spd, dup, fef; logic [7:0] e1, e2, e3;} psr_srow_type;
   typedef struct {logic [6:0] code; int ent; logic spd; logic [KBPS_W-1:0] kbps;} psr_rrow_type;
   logic core_clk, sys_rst;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, lastResp, crossSel;
   logic [2:0] polarityReversed, txFlowActive, rxFlowActive, speed100, fullDuplex, farEndFault;
   logic codingReset, softwareResetActive, irq;
   logic [NUM_PORTS*2*NQ*KBPS_W-1:0] rateLimitKbps;
   logic [31:0] d;
   int mismatches = 0;
   int checks = 0;
   psr_srow_type sRows[5];
   psr_rrow_type rRows[10];

   psr_port_status_regs #(.NUM_QUEUES(NQ)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .polarityReversed(polarityReversed), .txFlowActive(txFlowActive),
      .rxFlowActive(rxFlowActive), .speed100(speed100), .fullDuplex(fullDuplex),
      .farEndFault(farEndFault), .crossover_algorithm_select(crossSel),
      .coding_sublayer_reset(codingReset), .softwareResetActive(softwareResetActive),
      .rateLimitKbps(rateLimitKbps), .irq(irq));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Both channels offered together; each released when its own ready is seen
   task automatic wr(input logic [7:0] idx, input logic [7:0] val);
      s_axi_awaddr <= {22'h0, idx, 2'b00};
      s_axi_wdata <= {24'h0, val};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      lastResp = s_axi_bresp;
      // Ready left high, so a following call never re-drives it in one step
   endtask : wr

   task automatic rd(input logic [7:0] idx, output logic [31:0] data);
      s_axi_araddr <= {22'h0, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      data = s_axi_rdata;
      lastResp = s_axi_rresp;
   endtask : rd

   initial begin
      #(100 * 6000);
      mismatches++;
      test_done();
   end

   initial begin
      sRows = '{'{3'h7, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 8'ha0, 8'ha0, 8'h80},
         '{3'h7, 3'h0, 3'h0, 3'h7, 3'h0, 3'h0, 8'h84, 8'h84, 8'h84},
         '{3'h0, 3'h7, 3'h0, 3'h0, 3'h0, 3'h7, 8'h91, 8'h90, 8'h90},
         '{3'h0, 3'h2, 3'h5, 3'h0, 3'h3, 3'h6, 8'h8a, 8'h92, 8'h88},
         '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 8'h80, 8'h80, 8'h80}};
      rRows = '{'{7'h00, 0, 1'b1, 17'h186a0}, '{7'h01, 1, 1'b1, 17'h003e8},
         '{7'h63, 2, 1'b1, 17'h182b8}, '{7'h64, 0, 1'b1, 17'h186a0},
         '{7'h00, 4, 1'b0, 17'h02710}, '{7'h09, 5, 1'b0, 17'h02328},
         '{7'h0a, 6, 1'b0, 17'h02710}, '{7'h65, 0, 1'b1, 17'h00040},
         '{7'h73, 0, 1'b0, 17'h003c0}, '{7'h6c, 23, 1'b1, 17'h00200}};
      sys_rst = 1'b1;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'h1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {polarityReversed, txFlowActive, rxFlowActive, speed100, fullDuplex, farEndFault} = '0;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      chk({30'h0, crossSel}, 32'h3);
      rd(IDX_GLOBAL_RESET, d);
      chk(d, 32'h0);
      // Port 3 never shows polarity; polarity hidden at 100BT
      foreach (sRows[i]) begin
         polarityReversed <= sRows[i].pol;
         txFlowActive <= sRows[i].tx;
         rxFlowActive <= sRows[i].rx;
         speed100 <= sRows[i].spd;
         fullDuplex <= sRows[i].dup;
         farEndFault <= sRows[i].fef;
         repeat (2) @(posedge core_clk);
         rd(IDX_PORT1_STATUS1, d);
         chk(d, {24'h0, sRows[i].e1});
         rd(IDX_PORT2_STATUS1, d);
         chk(d, {24'h0, sRows[i].e2});
         rd(IDX_PORT3_STATUS1, d);
         chk(d, {24'h0, sRows[i].e3});
         chk({31'h0, irq}, 32'h0);
      end
      foreach (rRows[i]) begin
         speed100 <= {3{rRows[i].spd}};
         wr(IDX_RATE_BASE + 8'(rRows[i].ent), {1'b0, rRows[i].code});
         rd(IDX_RATE_BASE + 8'(rRows[i].ent), d);
         chk(d, {25'h0, rRows[i].code});
         d = {15'h0, rateLimitKbps[rRows[i].ent*KBPS_W +: KBPS_W]};
         chk(d, {15'h0, rRows[i].kbps});
      end
      speed100 <= 3'h0;
      // Crossover select on port 3 is stored but must not reach the PHY outputs
      wr(IDX_PORT1_STATUS1, 8'h00);
      chk({30'h0, crossSel}, 32'h2);
      wr(IDX_PORT3_STATUS1, 8'h00);
      chk({30'h0, crossSel}, 32'h2);
      rd(IDX_PORT1_STATUS1, d);
      chk(d, 32'h0);
      rd(8'h10, d);
      chk({d[29:0], lastResp}, {30'h0, RESP_DECERR});
      wr(IDX_INT_STATUS, 8'h07);
      wr(IDX_INT_MASK, 8'h01);
      chk({30'h0, lastResp}, {30'h0, RESP_OKAY});
      // Write with the low lane disabled must leave the mask alone
      s_axi_wstrb <= 4'h0;
      wr(IDX_INT_MASK, 8'h07);
      s_axi_wstrb <= 4'h1;
      chk({30'h0, lastResp}, {30'h0, RESP_OKAY});
      rd(IDX_INT_MASK, d);
      chk(d, 32'h1);
      wr(8'h10, 8'h55);
      chk({30'h0, lastResp}, {30'h0, RESP_DECERR});
      chk({31'h0, irq}, 32'h0);
      txFlowActive <= 3'h3;
      repeat (3) @(posedge core_clk);
      chk({31'h0, irq}, 32'h1);
      rd(IDX_INT_STATUS, d);
      chk(d, 32'h3);
      wr(IDX_INT_STATUS, 8'h01);
      @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      // Full reset asks for both bits at once
      wr(IDX_GLOBAL_RESET, 8'h11);
      @(posedge core_clk);
      chk({30'h0, softwareResetActive, codingReset}, 32'h3);
      chk({30'h0, crossSel}, 32'h3);
      rd(IDX_RATE_BASE + 8'd23, d);
      chk(d, 32'h0);
      rd(IDX_INT_MASK, d);
      chk(d, 32'h0);
      rd(IDX_GLOBAL_RESET, d);
      chk(d, 32'h11);
      wr(IDX_GLOBAL_RESET, 8'h00);
      @(posedge core_clk);
      chk({30'h0, softwareResetActive, codingReset}, 32'h0);
      rd(IDX_PORT1_STATUS1, d);
      chk(d, 32'h90);
      test_done();
   end
endmodule : testbench
